// >>> rtl/aih_pkg.sv
package aih_pkg;

  // ---------------------------------------------------------------
  // framing bytes and codes
  // ---------------------------------------------------------------
  localparam logic [7:0]  COMMAND_START_BYTE = 8'h01;
  localparam logic [7:0]  DATA_START_BYTE    = 8'h81;
  localparam logic [7:0]  PACKET_END_BYTE    = 8'h03;
  localparam logic [7:0]  CMD_AREA_INFO      = 8'h3b;
  localparam logic [7:0]  RESP_ERR_CODE      = 8'hbb;
  localparam logic [7:0]  LENGTH_HIGH_BYTE   = 8'h00;
  localparam logic [7:0]  LEN_INFO_LOW       = 8'h1a;
  localparam logic [7:0]  LEN_ERR_LOW        = 8'h0a;
  localparam logic [15:0] CMD_AREA_LEN       = 16'h0002;
  localparam logic [15:0] LEN_FMT_MAX        = 16'h0400;
  localparam logic [7:0]  ERR_FILL_BYTE      = 8'hff;

  // ---------------------------------------------------------------
  // status codes
  // ---------------------------------------------------------------
  localparam logic [7:0]  STS_PACKET_ERR     = 8'hc1;
  localparam logic [7:0]  STS_CHECKSUM_ERR   = 8'hc2;
  localparam logic [7:0]  STS_ACCEPT_ERR     = 8'hc3;
  localparam logic [7:0]  STS_PARAM_ERR      = 8'hc4;

  // ---------------------------------------------------------------
  // area type codes for the upper nibble of area_kind
  // ---------------------------------------------------------------
  localparam logic [3:0]  AREA_USER          = 4'h0;
  localparam logic [3:0]  AREA_DATA          = 4'h1;
  localparam logic [3:0]  AREA_CONFIG        = 4'h2;
  localparam logic [3:0]  AREA_EEP_CONFIG    = 4'h3;
  localparam logic [3:0]  AREA_EXT_FLASH     = 4'h4;

  // ---------------------------------------------------------------
  // reply byte positions and reset values
  // ---------------------------------------------------------------
  localparam logic [7:0]  POS_LNH            = 8'h01;
  localparam logic [7:0]  POS_LNL            = 8'h02;
  localparam logic [7:0]  POS_BODY           = 8'h03;
  localparam logic [7:0]  POS_SUM_OFS        = 8'h03;
  localparam logic [7:0]  POS_END_OFS        = 8'h04;
  localparam logic [7:0]  RST_BYTE           = 8'h00;
  localparam logic [15:0] RST_LEN            = 16'h0000;

  typedef enum logic [2:0] {
    AIH_WAIT,
    AIH_LNH,
    AIH_LNL,
    AIH_BODY,
    AIH_SUM,
    AIH_END,
    AIH_SEND
  } aih_state_t;

endpackage

// >>> rtl/aih_sum.sv
`timescale 1ns/10ps
module aih_sum
  import aih_pkg::*;
(
  input  wire logic       clk,   // clock
  input  wire logic       rst_n, // sync reset, low
  input  wire logic       clear, // restart the sum
  input  wire logic       add,   // add data this cycle
  input  wire logic [7:0] data,  // byte to add
  output logic      [7:0] sum    // 8-bit running sum
);

  typedef struct packed {
    logic [7:0] sum;
  } aih_sum_st_t;

  aih_sum_st_t s;
  aih_sum_st_t next_s;

  always_comb begin
    next_s = s;
    if (clear) begin
      next_s.sum = add ? data : RST_BYTE;
    end else if (add) begin
      next_s.sum = s.sum + data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s.sum <= RST_BYTE;
    end else begin
      s <= next_s;
    end
  end

  assign sum = s.sum;

endmodule

// >>> rtl/aih_body.sv
`timescale 1ns/10ps
module aih_body
  import aih_pkg::*;
(
  input  wire logic            ok,        // reply carries area information
  input  wire logic [7:0]      sts,       // status code for an error reply
  input  wire logic [7:0]      kind,      // area_kind byte
  input  wire logic [5:0][31:0] words,    // start, end, erase, write, read, crc
  input  wire logic [4:0]      bidx,      // body byte index
  output logic      [7:0]      body_byte  // byte at bidx
);

  logic [4:0]  k;
  logic [31:0] w;
  logic [31:0] sh;

  always_comb begin
    k  = bidx - 5'd2;
    w  = words[k[4:2]];
    sh = w >> {~k[1:0], 3'b000};
    if (bidx == 5'd0) begin
      body_byte = ok ? CMD_AREA_INFO : RESP_ERR_CODE;
    end else if (bidx == 5'd1) begin
      body_byte = ok ? kind : sts;
    end else if (ok) begin
      body_byte = sh[7:0];
    end else begin
      body_byte = ERR_FILL_BYTE;
    end
  end

endmodule

// >>> rtl/aih_handler.sv
`timescale 1ns/10ps
module aih_handler
  import aih_pkg::*;
(
  input  wire logic        clk,                // 25 MHz clock
  input  wire logic        rst_n,              // sync reset, low
  input  wire logic        rx_valid,           // received byte strobe
  input  wire logic [7:0]  rx_data,            // received byte
  output logic             tx_valid,           // reply byte valid
  output logic      [7:0]  tx_data,            // reply byte
  input  wire logic        tx_ready,           // link takes tx_data
  input  wire logic [7:0]  area_count,         // accessible areas
  input  wire logic        enc_write_no_reset, // encrypted write not yet reset
  output logic      [7:0]  area_sel,           // index into area table
  input  wire logic [3:0]  area_type,          // type of selected area
  input  wire logic [3:0]  area_inst,          // instance of selected area
  input  wire logic [31:0] area_start_address, // first address
  input  wire logic [31:0] area_end_address,   // last address
  input  wire logic [31:0] erase_unit,         // erase alignment
  input  wire logic [31:0] write_unit,         // write alignment
  input  wire logic [31:0] read_unit,          // read alignment
  input  wire logic [31:0] crc_unit,           // crc alignment
  output logic             busy                // reply in progress
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    aih_state_t      state;
    logic [15:0]     len;
    logic [15:0]     cnt;
    logic [7:0]      cmd;
    logic [7:0]      num;
    logic            ok;
    logic [7:0]      sts;
    logic [7:0]      kind;
    logic [5:0][31:0] words;
    logic [7:0]      idx;
    logic [7:0]      length_low_byte;
    logic            tx_valid;
    logic [7:0]      tx_data;
  } aih_st_t;

  aih_st_t s;
  aih_st_t next_s;

  logic       rx_clear;
  logic       rx_add;
  logic [7:0] rx_sum;
  logic       tx_clear;
  logic       tx_add;
  logic [7:0] tx_sum;
  logic [7:0] nidx;
  logic [7:0] nbyte;
  logic [7:0] body_byte;
  logic [4:0] bidx;
  logic       own;
  logic       load;
  logic       end_bad;
  logic       sum_bad;
  logic       fmt_bad;
  logic       len_bad;
  logic       num_bad;
  logic       enc_bad;

  // ---------------------------------------------------------------
  // checksums and body bytes
  // ---------------------------------------------------------------
  aih_sum u_rx_sum (
    .clk   (clk),
    .rst_n (rst_n),
    .clear (rx_clear),
    .add   (rx_add),
    .data  (rx_data),
    .sum   (rx_sum)
  );

  aih_sum u_tx_sum (
    .clk   (clk),
    .rst_n (rst_n),
    .clear (tx_clear),
    .add   (tx_add),
    .data  (nbyte),
    .sum   (tx_sum)
  );

  assign bidx = 5'(nidx - POS_BODY);

  aih_body u_body (
    .ok        (s.ok),
    .sts       (s.sts),
    .kind      (s.kind),
    .words     (s.words),
    .bidx      (bidx),
    .body_byte (body_byte)
  );

  // ---------------------------------------------------------------
  // error conditions, highest priority first
  // ---------------------------------------------------------------
  assign end_bad = (rx_data != PACKET_END_BYTE);
  assign sum_bad = (rx_sum != RST_BYTE);
  assign fmt_bad = (s.len == RST_LEN) || (s.len > LEN_FMT_MAX);
  assign len_bad = (s.len != CMD_AREA_LEN);
  assign num_bad = (s.num >= area_count);
  assign enc_bad = enc_write_no_reset;

  // only this command and a zero length, which carries no command, are answered
  assign own = (s.len == RST_LEN) || (s.cmd == CMD_AREA_INFO);

  // ---------------------------------------------------------------
  // next reply byte
  // ---------------------------------------------------------------
  always_comb begin
    // index of the byte to load next; a reply opens at zero
    nidx = (s.state == AIH_SEND) ? s.idx + 8'd1 : RST_BYTE;
    if (nidx == RST_BYTE) begin
      nbyte = DATA_START_BYTE;
    end else if (nidx == POS_LNH) begin
      nbyte = LENGTH_HIGH_BYTE;
    end else if (nidx == POS_LNL) begin
      nbyte = s.length_low_byte;
    end else if (nidx < s.length_low_byte + POS_SUM_OFS) begin
      nbyte = body_byte;
    end else if (nidx == s.length_low_byte + POS_SUM_OFS) begin
      nbyte = RST_BYTE - tx_sum;
    end else begin
      nbyte = PACKET_END_BYTE;
    end
  end

  // ---------------------------------------------------------------
  // receive, check and reply
  // ---------------------------------------------------------------
  always_comb begin
    next_s   = s;
    rx_clear = 1'b0;
    rx_add   = 1'b0;
    tx_clear = 1'b0;
    load     = 1'b0;
    case (s.state)
      AIH_WAIT: begin
        if (rx_valid && rx_data == COMMAND_START_BYTE) begin
          rx_clear     = 1'b1;
          next_s.cmd   = RST_BYTE;
          next_s.num   = RST_BYTE;
          next_s.cnt   = RST_LEN;
          next_s.state = AIH_LNH;
        end
      end
      AIH_LNH: begin
        if (rx_valid) begin
          rx_add       = 1'b1;
          next_s.len   = {rx_data, RST_BYTE};
          next_s.state = AIH_LNL;
        end
      end
      AIH_LNL: begin
        if (rx_valid) begin
          rx_add       = 1'b1;
          // a zero length has no body: the checksum byte comes next
          next_s.len   = {s.len[15:8], rx_data};
          next_s.state = ({s.len[15:8], rx_data} == RST_LEN) ? AIH_SUM : AIH_BODY;
        end
      end
      AIH_BODY: begin
        if (rx_valid) begin
          rx_add     = 1'b1;
          next_s.cnt = s.cnt + 16'd1;
          // body byte 0 is the command, byte 1 the area index
          if (s.cnt == RST_LEN) begin
            next_s.cmd = rx_data;
          end
          if (s.cnt == 16'd1) begin
            next_s.num = rx_data;
          end
          if (s.cnt + 16'd1 == s.len) begin
            next_s.state = AIH_SUM;
          end
        end
      end
      AIH_SUM: begin
        if (rx_valid) begin
          rx_add       = 1'b1;
          next_s.state = AIH_END;
        end
      end
      AIH_END: begin
        if (rx_valid) begin
          next_s.ok  = 1'b0;
          next_s.length_low_byte = LEN_ERR_LOW;
          if (end_bad) begin
            next_s.sts = STS_PACKET_ERR;
          end else if (sum_bad) begin
            next_s.sts = STS_CHECKSUM_ERR;
          end else if (fmt_bad) begin
            next_s.sts = STS_PACKET_ERR;
          end else if (len_bad) begin
            next_s.sts = STS_PACKET_ERR;
          end else if (num_bad) begin
            next_s.sts = STS_PARAM_ERR;
          end else if (enc_bad) begin
            next_s.sts = STS_ACCEPT_ERR;
          end else begin
            next_s.ok  = 1'b1;
            next_s.sts = RST_BYTE;
            next_s.length_low_byte = LEN_INFO_LOW;
          end
          // table values are taken with the end byte; area_sel held since the index
          next_s.kind  = {area_type, area_inst};
          next_s.words = {crc_unit,
                          read_unit,
                          write_unit,
                          erase_unit,
                          area_end_address,
                          area_start_address};
          if (own) begin
            tx_clear     = 1'b1;
            load         = 1'b1;
            next_s.state = AIH_SEND;
          end else begin
            next_s.state = AIH_WAIT;
          end
        end
      end
      AIH_SEND: begin
        // received bytes are dropped while the reply runs
        if (s.tx_valid && tx_ready) begin
          if (s.idx == s.length_low_byte + POS_END_OFS) begin
            next_s.tx_valid = 1'b0;
            next_s.state    = AIH_WAIT;
          end else begin
            load = 1'b1;
          end
        end
      end
      default: begin
        next_s.state = AIH_WAIT;
      end
    endcase
    if (load) begin
      next_s.idx      = nidx;
      next_s.tx_data  = nbyte;
      next_s.tx_valid = 1'b1;
    end
    tx_add = load && (nidx >= POS_LNH) && (nidx < s.length_low_byte + POS_SUM_OFS);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s.state    <= AIH_WAIT;
      s.len      <= RST_LEN;
      s.cnt      <= RST_LEN;
      s.cmd      <= RST_BYTE;
      s.num      <= RST_BYTE;
      s.ok       <= 1'b0;
      s.sts      <= RST_BYTE;
      s.kind     <= RST_BYTE;
      s.words    <= '0;
      s.idx      <= RST_BYTE;
      s.length_low_byte      <= RST_BYTE;
      s.tx_valid <= 1'b0;
      s.tx_data  <= RST_BYTE;
    end else begin
      s <= next_s;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign tx_valid = s.tx_valid;
  assign tx_data  = s.tx_data;
  assign area_sel = s.num;
  assign busy     = (s.state == AIH_SEND);

endmodule

// >>> sim/aih_properties.sv
`timescale 1ns/10ps
module aih_properties
  import aih_pkg::*;
(
  input wire logic        clk,                // clock
  input wire logic        rst_n,              // reset
  input wire logic        tx_valid,           // reply valid
  input wire logic [7:0]  tx_data,            // reply byte
  input wire logic        tx_ready,           // link ready
  input wire logic [7:0]  area_sel,           // table index
  input wire logic [3:0]  area_type,          // type nibble
  input wire logic [3:0]  area_inst,          // instance nibble
  input wire logic [31:0] area_start_address, // first address
  input wire logic        busy                // reply running
);
  logic [7:0] cnt;
  logic [7:0] ln;
  logic [7:0] acc;
  logic       take;

  assign take = tx_valid && tx_ready;

  // byte position, length low byte and running sum of the reply
  always_ff @(posedge clk) begin
    if (!rst_n || !busy) begin
      cnt <= 8'h00;
      acc <= 8'h00;
    end else if (take) begin
      cnt <= cnt + 8'h01;
      acc <= (cnt == 8'h00) ? acc : acc + tx_data;
      if (cnt == 8'h02) begin
        ln <= tx_data;
      end
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_stall;
    tx_valid && !tx_ready;
  endsequence
  sequence s_last;
    take && cnt == ln + 8'h04;
  endsequence
  sequence s_info(logic [7:0] pos);
    take && ln == LEN_INFO_LOW && cnt == pos;
  endsequence

  chk_hold_byte: assert property (s_stall |=> tx_valid && $stable(tx_data))
    else $error("reply byte changed while stalled");
  chk_reply_start: assert property ($rose(busy) |->
      tx_valid && tx_data == DATA_START_BYTE)
    else $error("reply does not open with data start");
  chk_busy_valid: assert property (tx_valid |-> busy)
    else $error("reply byte outside busy");
  chk_len_high: assert property (take && cnt == 8'h01 |->
      tx_data == LENGTH_HIGH_BYTE)
    else $error("length high byte wrong");
  chk_resp_code: assert property (take && cnt == 8'h03 |->
      (ln == LEN_ERR_LOW && tx_data == RESP_ERR_CODE) ||
      (ln == LEN_INFO_LOW && tx_data == CMD_AREA_INFO))
    else $error("response code does not fit length");
  chk_err_fill: assert property (take && ln == LEN_ERR_LOW &&
      cnt >= 8'h05 && cnt <= 8'h0c |-> tx_data == ERR_FILL_BYTE)
    else $error("error fill byte wrong");
  chk_kind_byte: assert property (s_info(8'h04) |-> tx_data == {area_type, area_inst})
    else $error("area kind byte wrong");
  chk_msb_first: assert property (s_info(8'h05) |-> tx_data == area_start_address[31:24])
    else $error("start address not sent high first");
  chk_reply_end: assert property (s_last |->
      tx_data == PACKET_END_BYTE ##1 !busy && !tx_valid)
    else $error("reply end or return to waiting wrong");
  chk_reply_sum: assert property (s_last |-> acc == 8'h00)
    else $error("reply checksum wrong");
  chk_sel_stable: assert property (busy |-> $stable(area_sel))
    else $error("area index moved during reply");
endmodule

// >>> sim/aih_host.sv
`timescale 1ns/10ps
module aih_host (
  input  wire logic       clk,      // clock
  input  wire logic       slow,     // stall every other cycle
  output logic            rx_valid, // byte strobe
  output logic      [7:0] rx_data,  // byte to device
  input  wire logic       tx_valid, // reply valid
  input  wire logic [7:0] tx_data,  // reply byte
  output logic            tx_ready  // host takes byte
);
  logic [7:0] got[$];

  initial begin
    rx_valid = 1'b0;
    rx_data  = 8'h00;
  end

  always @(negedge clk) begin
    tx_ready <= slow ? ~tx_ready : 1'b1;
  end

  always @(posedge clk) begin
    if (tx_valid && tx_ready) begin
      got.push_back(tx_data);
    end
  end

  // one byte strobe; the line shows the inverse byte when idle
  task put(input logic [7:0] b);
    @(negedge clk);
    rx_valid = 1'b1;
    rx_data  = b;
    @(negedge clk);
    rx_valid = 1'b0;
    rx_data  = ~b;
  endtask
endmodule

// >>> sim/aih_handler_bench.sv
`timescale 1ns/10ps
module aih_handler_bench
  import aih_pkg::*;
;
  typedef struct packed {
    logic [15:0] len;
    logic [7:0]  idx;
    logic [7:0]  dsum;
    logic [7:0]  endb;
    logic        enc;
    logic [7:0]  cnt;
    logic [7:0]  sts;
    logic        slow;
  } aih_row_t;

  logic        clk, rst_n, rx_valid, tx_valid, tx_ready, enc, busy, slow;
  logic [7:0]  rx_data, tx_data, area_count, area_sel;
  logic [3:0]  area_type, area_inst;
  logic [31:0] sa, ea, eu, wu, ru, cu;
  int          fail_count, total_checks, cyc;
  aih_row_t    r;
  aih_row_t    rows [15] = '{
    '{16'h0002, 8'h00, 8'h00, 8'h03, 1'b0, 8'h04, 8'h00, 1'b0},
    '{16'h0002, 8'h03, 8'h00, 8'h03, 1'b0, 8'h04, 8'h00, 1'b1},
    '{16'h0002, 8'h0c, 8'h00, 8'h03, 1'b0, 8'h0d, 8'h00, 1'b0},
    '{16'h0002, 8'h02, 8'h00, 8'h03, 1'b0, 8'h03, 8'h00, 1'b1},
    '{16'h0002, 8'h07, 8'h00, 8'h03, 1'b0, 8'h08, 8'h00, 1'b0},
    '{16'h0002, 8'h04, 8'h00, 8'h03, 1'b0, 8'h04, STS_PARAM_ERR, 1'b0},
    '{16'h0002, 8'h00, 8'h00, 8'h03, 1'b1, 8'h04, STS_ACCEPT_ERR, 1'b0},
    '{16'h0002, 8'h04, 8'h00, 8'h03, 1'b1, 8'h04, STS_PARAM_ERR, 1'b1},
    '{16'h0002, 8'h00, 8'h01, 8'h03, 1'b0, 8'h04, STS_CHECKSUM_ERR, 1'b0},
    '{16'h0002, 8'h00, 8'h01, 8'h04, 1'b0, 8'h04, STS_PACKET_ERR, 1'b0},
    '{16'h0003, 8'h00, 8'h01, 8'h03, 1'b0, 8'h04, STS_CHECKSUM_ERR, 1'b0},
    '{16'h0003, 8'h00, 8'h00, 8'h03, 1'b0, 8'h04, STS_PACKET_ERR, 1'b0},
    '{16'h0003, 8'h04, 8'h00, 8'h03, 1'b0, 8'h04, STS_PACKET_ERR, 1'b1},
    '{16'h0401, 8'h00, 8'h00, 8'h03, 1'b1, 8'h04, STS_PACKET_ERR, 1'b0},
    '{16'h0000, 8'h00, 8'h00, 8'h03, 1'b0, 8'h04, STS_PACKET_ERR, 1'b0}};

  function automatic logic [7:0] kind_of(input logic [7:0] s);
    return {{2'h0, s[1:0]} + {3'h0, s[2]}, ~s[3:0]};
  endfunction

  // area table; index 3 reports no erase support
  function automatic logic [31:0] tbl(input logic [7:0] s, input int k);
    if (k == 2 && s == 8'h03) return 32'h0;
    return {s, 4'(k + 1), 20'h0a5c3};
  endfunction

  assign {area_type, area_inst} = kind_of(area_sel);
  assign sa = tbl(area_sel, 0);
  assign ea = tbl(area_sel, 1);
  assign eu = tbl(area_sel, 2);
  assign wu = tbl(area_sel, 3);
  assign ru = tbl(area_sel, 4);
  assign cu = tbl(area_sel, 5);

  aih_host i_host (.clk(clk), .slow(slow), .rx_valid(rx_valid), .rx_data(rx_data),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));

  aih_handler i_dut (.clk(clk), .rst_n(rst_n), .rx_valid(rx_valid), .rx_data(rx_data),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .area_count(area_count),
    .enc_write_no_reset(enc), .area_sel(area_sel), .area_type(area_type),
    .area_inst(area_inst), .area_start_address(sa), .area_end_address(ea),
    .erase_unit(eu), .write_unit(wu), .read_unit(ru), .crc_unit(cu), .busy(busy));

  task cmp(input string nm, input logic [7:0] ex, input logic [7:0] sn);
    total_checks++;
    if (sn !== ex) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, ex, sn);
    end
  endtask

  task give_verdict;
    if (fail_count == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // stray byte first, then a framed request
  task pkt(input logic [15:0] len, input logic [7:0] idx, dsum, endb, cmd);
    logic [7:0] s, b;
    s = len[15:8] + len[7:0];
    i_host.put(8'h55);
    i_host.put(COMMAND_START_BYTE);
    i_host.put(len[15:8]);
    i_host.put(len[7:0]);
    for (int i = 0; i < len; i++) begin
      b = (i == 0) ? cmd : ((i == 1) ? idx : 8'h00);
      i_host.put(b);
      s = s + b;
    end
    i_host.put(8'h00 - s + dsum);
    i_host.put(endb);
  endtask

  task automatic exp_reply(input logic [7:0] sts, input logic [7:0] idx);
    logic [7:0]  e[$];
    logic [7:0]  s;
    logic [31:0] w;
    logic [31:0] a;
    logic [31:0] x;
    int          n;
    e = {DATA_START_BYTE, LENGTH_HIGH_BYTE};
    if (sts === 8'h00) begin
      e = {e, LEN_INFO_LOW, CMD_AREA_INFO, kind_of(idx)};
      for (int k = 0; k < 6; k++) begin
        w = tbl(idx, k);
        e = {e, w[31:24], w[23:16], w[15:8], w[7:0]};
      end
    end else begin
      e = {e, LEN_ERR_LOW, RESP_ERR_CODE, sts};
      repeat (8) e.push_back(ERR_FILL_BYTE);
    end
    s = 8'h00;
    foreach (e[i]) s = (i > 0) ? s + e[i] : s;
    e = {e, 8'h00 - s, PACKET_END_BYTE};
    n = 0;
    while (i_host.got.size() < e.size() && n < 300) begin
      @(negedge clk);
      n++;
    end
    repeat (3) @(negedge clk);
    cmp("reply size", 8'(e.size()), 8'(i_host.got.size()));
    if (i_host.got.size() == e.size()) begin
      foreach (e[i]) cmp("reply byte", e[i], i_host.got[i]);
    end
    if (sts === 8'h00 && i_host.got.size() == e.size()) begin
      // host view: start address aligned down to the reported write unit
      a = {i_host.got[5], i_host.got[6], i_host.got[7], i_host.got[8]};
      w = {i_host.got[17], i_host.got[18], i_host.got[19], i_host.got[20]};
      x = tbl(idx, 0);
      cmp("aligned start", 8'(x - x % tbl(idx, 3)), 8'(a - a % w));
    end
    cmp("busy", 8'h00, {7'h00, busy});
    i_host.got.delete();
  endtask

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      fail_count++;
      give_verdict;
    end
  end

  initial begin
    rst_n = 1'b0;
    enc = 1'b0;
    slow = 1'b0;
    area_count = 8'h04;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    foreach (rows[i]) begin
      r = rows[i];
      area_count = r.cnt;
      enc = r.enc;
      slow = r.slow;
      pkt(r.len, r.idx, r.dsum, r.endb, CMD_AREA_INFO);
      exp_reply(r.sts, r.idx);
    end
    pkt(16'h0002, 8'h00, 8'h00, 8'h03, 8'h3c);
    repeat (40) @(negedge clk);
    cmp("unknown command reply", 8'h00, 8'(i_host.got.size()));
    pkt(16'h0002, 8'h01, 8'h00, 8'h03, CMD_AREA_INFO);
    repeat (6) @(negedge clk);
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    cmp("tx_valid in reset", 8'h00, {7'h00, tx_valid});
    cmp("busy in reset", 8'h00, {7'h00, busy});
    cmp("area_sel in reset", 8'h00, area_sel);
    rst_n = 1'b1;
    i_host.got.delete();
    pkt(16'h0002, 8'h03, 8'h00, 8'h03, CMD_AREA_INFO);
    exp_reply(8'h00, 8'h03);
    give_verdict;
  end
endmodule

bind aih_handler aih_properties i_chk (.clk(clk), .rst_n(rst_n), .tx_valid(tx_valid),
  .tx_data(tx_data), .tx_ready(tx_ready), .area_sel(area_sel), .area_type(area_type),
  .area_inst(area_inst), .area_start_address(area_start_address), .busy(busy));
